// ===== rtl/boundary_scan_test_port.sv
// Boundary-scan test port: controller, instruction and data registers, pin muxing.
// Assumes tck comes from an outside test controller; clk runs the switch pins.
module boundary_scan_test_port #(
	parameter logic [31:0] ID_VALUE = 32'h0000_0001 // Arbitrary code, LSB set
) (
	// System clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Test access pins
	input wire logic tck,
	input wire logic tms_in,
	input wire logic tms_driven,
	input wire logic tdi_in,
	input wire logic tdi_driven,
	input wire logic trst_n_in,
	input wire logic trst_driven,
	output logic tdo_out,
	output logic tdo_oe_n,
	// Switch core and device pins
	input wire scan_port_pkg::pin_out_s core_out,
	input wire scan_port_pkg::pin_in_s pin_in,
	output scan_port_pkg::pin_out_s pin_out
);

	localparam int BL = scan_port_pkg::BSR_LEN;
	localparam int IW = scan_port_pkg::IR_W;

	logic tms;
	logic tdi;
	logic tap_rst_n;
	scan_port_pkg::tap_state_e state_r, state_nxt;
	logic [IW-1:0] ir_r, ir_nxt, ir_sh_r, ir_sh_nxt;
	logic byp_r, byp_nxt;
	logic [scan_port_pkg::ID_W-1:0] id_sh_r, id_sh_nxt;
	logic [BL-1:0] bsr_sh_r, bsr_sh_nxt, bsr_upd_r, bsr_upd_nxt;
	logic tdo_r, tdo_nxt, tdo_en_r, tdo_en_nxt;
	scan_port_pkg::dr_sel_e dr_sel;
	logic [BL-1:0] obs_r, obs_nxt, obs_s;
	logic [BL:0] upd_s;
	scan_port_pkg::pin_in_s pin_in_s;
	scan_port_pkg::pin_out_s pin_out_r, pin_out_nxt;

	// Instruction to data register; unknown codes fall to bypass
	function automatic scan_port_pkg::dr_sel_e decode_ir(logic [IW-1:0] ir);
		case (ir)
			scan_port_pkg::IR_EXTEST: decode_ir = scan_port_pkg::DR_BOUNDARY;
			scan_port_pkg::IR_SAMPLE: decode_ir = scan_port_pkg::DR_BOUNDARY;
			scan_port_pkg::IR_IDCODE: decode_ir = scan_port_pkg::DR_IDENT;
			default: decode_ir = scan_port_pkg::DR_BYPASS;
		endcase
	endfunction

	// Pin states to boundary cells
	function automatic logic [BL-1:0] to_cells(scan_port_pkg::pin_out_s o,
		scan_port_pkg::pin_in_s i);
		logic [BL-1:0] c;
		int k;
		c = '0;
		for (k = 0; k < 8; k++) begin
			c[scan_port_pkg::SOUT_LO_BASE + 2 * (7 - k)] = ~o.serial_out_oe_n[k];
			c[scan_port_pkg::SOUT_LO_BASE + 2 * (7 - k) + 1] = o.serial_out_stream[k];
			c[scan_port_pkg::SOUT_HI_BASE + 2 * (7 - k)] = ~o.serial_out_oe_n[k + 8];
			c[scan_port_pkg::SOUT_HI_BASE + 2 * (7 - k) + 1] = o.serial_out_stream[k + 8];
			c[scan_port_pkg::ADDR_BASE + 7 - k] = i.addr[k];
		end
		c[scan_port_pkg::DRIVE_EN_IN] = i.output_drive_enable_pin;
		c[scan_port_pkg::CSO_CTRL] = ~o.control_stream_oe_n;
		c[scan_port_pkg::CSO_OUT] = o.control_stream_out;
		c[scan_port_pkg::ACK_OUT] = o.transfer_acknowledge;
		for (k = 0; k < 16; k++) begin
			c[scan_port_pkg::DATA_BASE + 3 * (15 - k)] = ~o.data_oe_n[k];
			c[scan_port_pkg::DATA_BASE + 3 * (15 - k) + 1] = o.data_out[k];
			c[scan_port_pkg::DATA_BASE + 3 * (15 - k) + 2] = i.data_in[k];
			c[scan_port_pkg::SIN_BASE + 15 - k] = i.serial_in_stream[k];
		end
		c[scan_port_pkg::MODE_SEL_IN] = i.interface_mode_select;
		c[scan_port_pkg::ADDR_STROBE_IN] = i.address_strobe;
		c[scan_port_pkg::CS_IN] = i.chip_select;
		c[scan_port_pkg::RW_IN] = i.read_write;
		c[scan_port_pkg::DATA_STROBE_IN] = i.data_strobe_pin;
		c[scan_port_pkg::WIDE_PULSE_IN] = i.wide_pulse_select;
		c[scan_port_pkg::RST_IN] = i.reset;
		c[scan_port_pkg::CLK_IN] = i.clock;
		c[scan_port_pkg::FRAME_EVAL_IN] = i.frame_evaluation_input;
		c[scan_port_pkg::FRAME_PULSE_IN] = i.frame_pulse_input;
		to_cells = c;
	endfunction

	// Boundary cells to pin drive; a control cell at one turns its driver on
	function automatic scan_port_pkg::pin_out_s from_cells(logic [BL-1:0] c);
		scan_port_pkg::pin_out_s o;
		int k;
		o = '0;
		for (k = 0; k < 8; k++) begin
			o.serial_out_oe_n[k] = ~c[scan_port_pkg::SOUT_LO_BASE + 2 * (7 - k)];
			o.serial_out_stream[k] = c[scan_port_pkg::SOUT_LO_BASE + 2 * (7 - k) + 1];
			o.serial_out_oe_n[k + 8] = ~c[scan_port_pkg::SOUT_HI_BASE + 2 * (7 - k)];
			o.serial_out_stream[k + 8] = c[scan_port_pkg::SOUT_HI_BASE + 2 * (7 - k) + 1];
		end
		for (k = 0; k < 16; k++) begin
			o.data_oe_n[k] = ~c[scan_port_pkg::DATA_BASE + 3 * (15 - k)];
			o.data_out[k] = c[scan_port_pkg::DATA_BASE + 3 * (15 - k) + 1];
		end
		o.control_stream_oe_n = ~c[scan_port_pkg::CSO_CTRL];
		o.control_stream_out = c[scan_port_pkg::CSO_OUT];
		o.transfer_acknowledge = c[scan_port_pkg::ACK_OUT];
		from_cells = o;
	endfunction

	// Pull-ups stand in for undriven test pins
	assign tms = tms_driven ? tms_in : 1'b1;
	assign tdi = tdi_driven ? tdi_in : 1'b1;
	assign tap_rst_n = trst_driven ? trst_n_in : 1'b1;
	assign dr_sel = decode_ir(ir_r);

	// Controller and shift registers, next values
	always_comb begin
		state_nxt = state_r;
		ir_nxt = ir_r;
		ir_sh_nxt = ir_sh_r;
		byp_nxt = byp_r;
		id_sh_nxt = id_sh_r;
		bsr_sh_nxt = bsr_sh_r;
		bsr_upd_nxt = bsr_upd_r;
		case (state_r)
			scan_port_pkg::TEST_LOGIC_RESET: state_nxt = tms ? scan_port_pkg::TEST_LOGIC_RESET
				: scan_port_pkg::RUN_IDLE;
			scan_port_pkg::RUN_IDLE: state_nxt = tms ? scan_port_pkg::SELECT_DR
				: scan_port_pkg::RUN_IDLE;
			scan_port_pkg::SELECT_DR: state_nxt = tms ? scan_port_pkg::SELECT_IR
				: scan_port_pkg::CAPTURE_DR;
			scan_port_pkg::CAPTURE_DR: state_nxt = tms ? scan_port_pkg::EXIT1_DR
				: scan_port_pkg::SHIFT_DR;
			scan_port_pkg::SHIFT_DR: state_nxt = tms ? scan_port_pkg::EXIT1_DR
				: scan_port_pkg::SHIFT_DR;
			scan_port_pkg::EXIT1_DR: state_nxt = tms ? scan_port_pkg::UPDATE_DR
				: scan_port_pkg::PAUSE_DR;
			scan_port_pkg::PAUSE_DR: state_nxt = tms ? scan_port_pkg::EXIT2_DR
				: scan_port_pkg::PAUSE_DR;
			scan_port_pkg::EXIT2_DR: state_nxt = tms ? scan_port_pkg::UPDATE_DR
				: scan_port_pkg::SHIFT_DR;
			scan_port_pkg::UPDATE_DR: state_nxt = tms ? scan_port_pkg::SELECT_DR
				: scan_port_pkg::RUN_IDLE;
			scan_port_pkg::SELECT_IR: state_nxt = tms ? scan_port_pkg::TEST_LOGIC_RESET
				: scan_port_pkg::CAPTURE_IR;
			scan_port_pkg::CAPTURE_IR: state_nxt = tms ? scan_port_pkg::EXIT1_IR
				: scan_port_pkg::SHIFT_IR;
			scan_port_pkg::SHIFT_IR: state_nxt = tms ? scan_port_pkg::EXIT1_IR
				: scan_port_pkg::SHIFT_IR;
			scan_port_pkg::EXIT1_IR: state_nxt = tms ? scan_port_pkg::UPDATE_IR
				: scan_port_pkg::PAUSE_IR;
			scan_port_pkg::PAUSE_IR: state_nxt = tms ? scan_port_pkg::EXIT2_IR
				: scan_port_pkg::PAUSE_IR;
			scan_port_pkg::EXIT2_IR: state_nxt = tms ? scan_port_pkg::UPDATE_IR
				: scan_port_pkg::SHIFT_IR;
			scan_port_pkg::UPDATE_IR: state_nxt = tms ? scan_port_pkg::SELECT_DR
				: scan_port_pkg::RUN_IDLE;
			default: state_nxt = scan_port_pkg::TEST_LOGIC_RESET;
		endcase
		case (state_r)
			scan_port_pkg::TEST_LOGIC_RESET: ir_nxt = scan_port_pkg::IR_RESET;
			scan_port_pkg::CAPTURE_IR: ir_sh_nxt = scan_port_pkg::IR_CAPTURE;
			scan_port_pkg::SHIFT_IR: ir_sh_nxt = {tdi, ir_sh_r[IW-1:1]};
			scan_port_pkg::UPDATE_IR: ir_nxt = ir_sh_r;
			scan_port_pkg::CAPTURE_DR: begin
				byp_nxt = 1'b0;
				id_sh_nxt = ID_VALUE;
				bsr_sh_nxt = obs_s; // Pins as last seen, a few tck cycles old
			end
			scan_port_pkg::SHIFT_DR: begin
				case (dr_sel)
					scan_port_pkg::DR_IDENT: id_sh_nxt = {tdi, id_sh_r[31:1]};
					scan_port_pkg::DR_BOUNDARY: bsr_sh_nxt = {tdi, bsr_sh_r[BL-1:1]};
					default: byp_nxt = tdi;
				endcase
			end
			scan_port_pkg::UPDATE_DR: begin
				if (dr_sel == scan_port_pkg::DR_BOUNDARY) begin
					bsr_upd_nxt = bsr_sh_r;
				end
			end
			default: begin
			end
		endcase
	end

	// Test reset is asynchronous so a stopped tck cannot block it
	always_ff @(posedge tck or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			state_r <= scan_port_pkg::TEST_LOGIC_RESET;
			ir_r <= scan_port_pkg::IR_RESET;
			ir_sh_r <= scan_port_pkg::IR_CAPTURE;
			byp_r <= 1'b0;
			id_sh_r <= '0;
			bsr_sh_r <= '0;
			bsr_upd_r <= scan_port_pkg::BSR_RESET;
		end else begin
			state_r <= state_nxt;
			ir_r <= ir_nxt;
			ir_sh_r <= ir_sh_nxt;
			byp_r <= byp_nxt;
			id_sh_r <= id_sh_nxt;
			bsr_sh_r <= bsr_sh_nxt;
			bsr_upd_r <= bsr_upd_nxt;
		end
	end

	// Serial output bit and driver enable, next values
	always_comb begin
		tdo_nxt = 1'b0;
		tdo_en_nxt = 1'b0;
		if (state_r == scan_port_pkg::SHIFT_IR) begin
			tdo_nxt = ir_sh_r[0];
			tdo_en_nxt = 1'b1;
		end else if (state_r == scan_port_pkg::SHIFT_DR) begin
			tdo_en_nxt = 1'b1;
			case (dr_sel)
				scan_port_pkg::DR_IDENT: tdo_nxt = id_sh_r[0];
				scan_port_pkg::DR_BOUNDARY: tdo_nxt = bsr_sh_r[0];
				default: tdo_nxt = byp_r;
			endcase
		end
	end

	// Falling edge gives the controller half a period of hold on tdo
	always_ff @(negedge tck or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			tdo_r <= 1'b0;
			tdo_en_r <= 1'b0;
		end else begin
			tdo_r <= tdo_nxt;
			tdo_en_r <= tdo_en_nxt;
		end
	end

	assign tdo_out = tdo_r;
	assign tdo_oe_n = ~tdo_en_r;

	// Pin inputs come from outside and are synchronised into clk
	level_sync #(.W($bits(scan_port_pkg::pin_in_s))) u_pin_sync (
		.clk(clk),
		.rst(sys_rst),
		.d(pin_in),
		.q(pin_in_s)
	);

	// Test mode and update cells cross into clk; bits may land a cycle apart
	level_sync #(.W(BL + 1)) u_upd_sync (
		.clk(clk),
		.rst(sys_rst),
		.d({(ir_r == scan_port_pkg::IR_EXTEST), bsr_upd_r}),
		.q(upd_s)
	);

	// Observed pin states cross into tck for capture
	level_sync #(.W(BL)) u_obs_sync (
		.clk(tck),
		.rst(~tap_rst_n),
		.d(obs_r),
		.q(obs_s)
	);

	// Core drives pins except under external test or system reset
	always_comb begin
		pin_out_nxt = upd_s[BL] ? from_cells(upd_s[BL-1:0]) : core_out;
		obs_nxt = to_cells(pin_out_r, pin_in_s);
		if (sys_rst) begin
			pin_out_nxt = '1; // Drivers off, all enables high
			obs_nxt = '0;
		end
	end

	// Pin and observation registers
	always_ff @(posedge clk) begin
		pin_out_r <= pin_out_nxt;
		obs_r <= obs_nxt;
	end

	assign pin_out = pin_out_r;

endmodule

// ===== rtl/scan_port_pkg.sv
// Shared constants, states and pin groups of the boundary-scan test port.
// Assumes a switch core that hands its pin drive values over as pin_out_s.
package scan_port_pkg;

	// Register lengths
	localparam int IR_W = 3;
	localparam int ID_W = 32;
	localparam int BSR_LEN = 118;

	// Instruction encodings; anything not listed decodes as bypass
	localparam logic [2:0] IR_EXTEST = 3'h0;
	localparam logic [2:0] IR_SAMPLE = 3'h1;
	localparam logic [2:0] IR_IDCODE = 3'h2;
	localparam logic [2:0] IR_BYPASS = 3'h7;
	localparam logic [2:0] IR_CAPTURE = 3'h1;
	localparam logic [2:0] IR_RESET = IR_IDCODE;

	// Boundary cell positions, cell 0 leaves first
	localparam int SOUT_LO_BASE = 0;
	localparam int DRIVE_EN_IN = 16;
	localparam int CSO_CTRL = 17;
	localparam int CSO_OUT = 18;
	localparam int ACK_OUT = 19;
	localparam int DATA_BASE = 20;
	localparam int MODE_SEL_IN = 68;
	localparam int ADDR_STROBE_IN = 69;
	localparam int CS_IN = 70;
	localparam int RW_IN = 71;
	localparam int DATA_STROBE_IN = 72;
	localparam int ADDR_BASE = 73;
	localparam int WIDE_PULSE_IN = 81;
	localparam int RST_IN = 82;
	localparam int CLK_IN = 83;
	localparam int FRAME_EVAL_IN = 84;
	localparam int FRAME_PULSE_IN = 85;
	localparam int SIN_BASE = 86;
	localparam int SOUT_HI_BASE = 102;

	// Reset value of the update latches: all drivers off under test
	localparam logic [BSR_LEN-1:0] BSR_RESET = '0;

	// Test port controller states
	typedef enum logic [3:0] {
		EXIT2_DR = 4'h0,
		EXIT1_DR = 4'h1,
		SHIFT_DR = 4'h2,
		PAUSE_DR = 4'h3,
		SELECT_IR = 4'h4,
		UPDATE_DR = 4'h5,
		CAPTURE_DR = 4'h6,
		SELECT_DR = 4'h7,
		EXIT2_IR = 4'h8,
		EXIT1_IR = 4'h9,
		SHIFT_IR = 4'hA,
		PAUSE_IR = 4'hB,
		RUN_IDLE = 4'hC,
		UPDATE_IR = 4'hD,
		CAPTURE_IR = 4'hE,
		TEST_LOGIC_RESET = 4'hF
	} tap_state_e;

	// Data register chosen by the instruction
	typedef enum logic [1:0] {
		DR_BYPASS = 2'h0,
		DR_IDENT = 2'h1,
		DR_BOUNDARY = 2'h2
	} dr_sel_e;

	// Pin outputs; an enable low means the driver is on
	typedef struct packed {
		logic [15:0] serial_out_stream;
		logic [15:0] serial_out_oe_n;
		logic control_stream_out;
		logic control_stream_oe_n;
		logic transfer_acknowledge;
		logic [15:0] data_out;
		logic [15:0] data_oe_n;
	} pin_out_s;

	// Pin inputs as seen at the device boundary
	typedef struct packed {
		logic output_drive_enable_pin;
		logic [15:0] data_in;
		logic interface_mode_select;
		logic address_strobe;
		logic chip_select;
		logic read_write;
		logic data_strobe_pin;
		logic [7:0] addr;
		logic wide_pulse_select;
		logic reset;
		logic clock;
		logic frame_evaluation_input;
		logic frame_pulse_input;
		logic [15:0] serial_in_stream;
	} pin_in_s;

endpackage

// ===== rtl/level_sync.sv
// Two-flop level synchroniser, any width.
// Assumes d is a level that holds long enough for the destination clock.
module level_sync #(
	parameter int W = 1
) (
	// Destination clock and synchronous reset
	input wire logic clk,
	input wire logic rst,
	// Level in, synchronised level out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] q_r;
	logic [W-1:0] q_nxt;

	// First stage feeds only the second stage
	always_comb begin
		meta_nxt = rst ? '0 : d;
		q_nxt = rst ? '0 : meta_r;
	end

	// Register both stages
	always_ff @(posedge clk) begin
		meta_r <= meta_nxt;
		q_r <= q_nxt;
	end

	assign q = q_r;

endmodule

// ===== verif/scan_port_props.sv
// Concurrent checks on the ports of the boundary-scan test port.
// Assumes it is bound into every instance and sees the top's ports only.
module scan_port_props #(
	parameter logic [31:0] ID_VALUE = 32'h0000_0001 // Arbitrary code, LSB set
) (
	// System side
	input wire logic clk,
	input wire logic sys_rst,
	input wire scan_port_pkg::pin_out_s core_out,
	input wire scan_port_pkg::pin_out_s pin_out,
	// Test access side
	input wire logic tck,
	input wire logic tms_in,
	input wire logic tms_driven,
	input wire logic trst_n_in,
	input wire logic trst_driven,
	input wire logic tdo_out,
	input wire logic tdo_oe_n
);
	timeunit 1ns;
	timeprecision 100ps;
	// Pin levels with the pull-ups applied
	wire logic tms_eff = tms_driven ? tms_in : 1'b1;
	wire logic trst_on = trst_driven && !trst_n_in;
	logic [1:0] rise_r;
	logic [1:0] rise_nxt;

	// Output pair held at the rising edge; it may only move on the falling one
	always_comb rise_nxt = {tdo_oe_n, tdo_out};
	always_ff @(posedge tck) rise_r <= rise_nxt;

	// Five highs always reach test logic reset, then a walk into shift-DR
	sequence to_shift_dr;
		tms_eff [*5] ##1 !tms_eff ##1 tms_eff ##1 !tms_eff ##1 !tms_eff;
	endsequence

	a_idcode_first: assert property (@(posedge tck) disable iff (trst_on)
		to_shift_dr |-> ##1 (!tdo_oe_n && tdo_out == ID_VALUE[0]))
		else $error("identification bit 0 wrong");
	a_idcode_second: assert property (@(posedge tck) disable iff (trst_on)
		to_shift_dr ##1 !tms_eff |-> ##1 (!tdo_oe_n && tdo_out == ID_VALUE[1]))
		else $error("identification bit 1 wrong");
	a_exit_releases_tdo: assert property (@(posedge tck) disable iff (trst_on)
		to_shift_dr ##1 tms_eff |-> ##1 tdo_oe_n)
		else $error("tdo still driven after shift");
	a_ir_capture_bit: assert property (@(posedge tck) disable iff (trst_on)
		tms_eff [*5] ##1 !tms_eff ##1 tms_eff [*2] ##1 !tms_eff [*2]
		|-> ##1 (!tdo_oe_n && tdo_out))
		else $error("instruction capture bit wrong");
	a_tdo_falls_only: assert property (@(negedge tck) disable iff (trst_on)
		{tdo_oe_n, tdo_out} == rise_r)
		else $error("tdo moved on a rising edge");
	a_idle_no_drive: assert property (@(posedge tck) disable iff (trst_on)
		tms_eff [*5] |-> tdo_oe_n)
		else $error("tdo driven in reset state");
	a_trst_quiet: assert property (@(posedge clk) disable iff (sys_rst)
		trst_on |-> (tdo_oe_n && !tdo_out))
		else $error("tdo active under test reset");
	a_core_passes: assert property (@(posedge clk) disable iff (sys_rst)
		(!sys_rst && trst_on) [*4] |=> pin_out == $past(core_out))
		else $error("pins do not follow the core");

	// Main scenarios reached
	c_shift_dr: cover property (@(posedge tck) to_shift_dr);
	c_trst: cover property (@(posedge clk) trst_on);
	c_drive_off: cover property (@(posedge tck) !tdo_oe_n ##1 tdo_oe_n);
endmodule

bind boundary_scan_test_port scan_port_props #(.ID_VALUE(ID_VALUE)) u_props (.clk, .sys_rst,
	.core_out, .pin_out, .tck, .tms_in, .tms_driven, .trst_n_in, .trst_driven, .tdo_out,
	.tdo_oe_n);

// ===== verif/tap_ctl.sv
// Model of the outside test controller that owns tck, tms, tdi and trst.
// Assumes tck only runs inside its own tasks; it rests low between frames.
module tap_ctl (
	// Test access pins toward the port
	output logic tck,
	output logic tms_in,
	output logic tms_driven,
	output logic tdi_in,
	output logic tdi_driven,
	output logic trst_n_in,
	output logic trst_driven,
	// Serial answer
	input wire logic tdo_out,
	input wire logic tdo_oe_n
);
	timeunit 1ns;
	timeprecision 100ps;
	// A released tdo reads inverted, so a missing driver never passes as data
	wire logic tdo_w = tdo_oe_n ? ~tdo_out : tdo_out;

	// Idle: clock low, tdi and trst left to their pull-ups
	initial begin
		tck = 0;
		tms_in = 1;
		tms_driven = 1;
		tdi_in = 1;
		tdi_driven = 0;
		trst_n_in = 1;
		trst_driven = 0;
	end

	// One 12 ns period; tdo is taken just before the rising edge
	task automatic step(input logic m, input logic d, output logic o);
		tms_in = m;
		tdi_in = d;
		#6 o = tdo_w;
		tck = 1;
		#6 tck = 0;
	endtask

	// Leave tms undriven at a stale low for five clocks, then go to idle
	task automatic tlr();
		logic o;
		tms_driven = 0;
		repeat (5) step(0, 1, o);
		tms_driven = 1;
		step(0, 1, o);
	endtask

	// Test reset held over a few clocks, then released to its pull-up
	task automatic treset();
		logic o;
		trst_driven = 1;
		trst_n_in = 0;
		repeat (4) step(1, 1, o);
		#200 trst_n_in = 1;
		trst_driven = 0;
		step(0, 1, o);
	endtask

	// Idle to idle scan of n bits, LSB first; unused result bits stay zero
	task automatic scan(input logic ir, input int n, input logic [127:0] din,
		output logic [127:0] dout);
		logic o;
		dout = '0;
		step(1, 1, o);
		if (ir) step(1, 1, o);
		step(0, 1, o);
		step(0, 1, o);
		tdi_driven = 1;
		for (int k = 0; k < n; k++) begin
			step(k == n - 1, din[k], o);
			dout[k] = o;
		end
		tdi_driven = 0;
		step(1, 1, o);
		step(0, 1, o);
	endtask
endmodule

// ===== verif/boundary_scan_test_port_tb.sv
// Self-checking bench for the boundary-scan test port.
// Assumes the controller model tap_ctl and the bound checker are compiled alongside.
module boundary_scan_test_port_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [31:0] ID_P = 32'h1357_9BDF; // Arbitrary code, LSB set
	logic clk, sys_rst, tck, tms_in, tms_driven, tdi_in, tdi_driven;
	logic trst_n_in, trst_driven, tdo_out, tdo_oe_n;
	scan_port_pkg::pin_out_s core_out, pin_out;
	scan_port_pkg::pin_in_s pin_in;
	int err_total, tests_run;
	logic [127:0] got;

	boundary_scan_test_port #(.ID_VALUE(ID_P)) dut (.clk, .sys_rst, .tck, .tms_in,
		.tms_driven, .tdi_in, .tdi_driven, .trst_n_in, .trst_driven, .tdo_out, .tdo_oe_n,
		.core_out, .pin_in, .pin_out);
	tap_ctl ctl (.tck, .tms_in, .tms_driven, .tdi_in, .tdi_driven, .trst_n_in,
		.trst_driven, .tdo_out, .tdo_oe_n);

	// 40 MHz system clock
	initial begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end

	task automatic chk(input logic [127:0] g, input logic [127:0] e);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic results();
		$display("Checks %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	// Test reset must undo a bypass instruction
	task automatic s_trst();
		ctl.treset();
		ctl.scan(1, 3, 128'h7, got);
		chk(got, 128'h1);
		ctl.treset();
		ctl.scan(0, 32, '0, got);
		chk(got, {96'h0, ID_P});
	endtask

	// Pulled-up tms walks home; 40 bits show the register is exactly 32 long
	task automatic s_idcode();
		ctl.tlr();
		ctl.scan(0, 1, '0, got);
		chk(got, {127'h0, ID_P[0]});
		ctl.tlr(); // Walk home again so a long shift follows the reset walk
		ctl.scan(0, 40, 128'hC3, got);
		chk(got, {88'h0, 8'hC3, ID_P});
	endtask

	// Unassigned and all-ones opcodes give one stage; core keeps running meanwhile
	task automatic s_bypass();
		ctl.tlr(); // Reset walk straight into an instruction scan
		for (int op = 3; op < 8; op++) begin
			ctl.scan(1, 3, 128'(op), got);
			chk(got, 128'h1);
			fork
				ctl.scan(0, 8, 128'hB4, got);
				for (int k = 0; k < 4; k++) begin
					@(posedge clk) core_out <= scan_port_pkg::pin_out_s'(67'h5A5A + 67'(op * k));
					@(posedge clk) #1 chk(128'(pin_out), 128'(core_out));
				end
			join
			chk(got, 128'h68);
		end
	endtask

	// One long pass checks capture and length and preloads cells for the pin test
	task automatic s_boundary();
		logic [117:0] v;
		scan_port_pkg::pin_out_s e;
		v = (118'h1 << 102) | 118'h3E0003;
		e = '{serial_out_stream: 16'h0080, serial_out_oe_n: 16'h7F7F, control_stream_out: 1,
			control_stream_oe_n: 0, transfer_acknowledge: 1, data_out: 16'h8000,
			data_oe_n: 16'h7FFF};
		@(posedge clk) pin_in <= '{output_drive_enable_pin: 1, data_in: 16'h8000,
			address_strobe: 1, addr: 8'h80, serial_in_stream: 16'h8001, default: 0};
		repeat (10) @(posedge clk);
		ctl.scan(1, 3, 128'h1, got);
		chk(got, 128'h1);
		ctl.scan(0, 128, {v, 10'h2A5}, got);
		chk(128'(got[101:68]), 128'h2_0004_0022);
		chk(128'({got[127:118], got[22], got[16]}), {116'h0, 10'h2A5, 2'h3});
		ctl.scan(1, 3, 128'h0, got);
		@(posedge clk) core_out <= '1;
		repeat (6) @(posedge clk);
		#1 chk(128'(pin_out), 128'(e));
		ctl.treset();
	endtask

	// Main sequence
	initial begin
		sys_rst = 1;
		core_out = '0;
		pin_in = '0;
		err_total = 0;
		tests_run = 0;
		repeat (12) @(posedge clk);
		sys_rst <= 0;
		repeat (4) @(posedge clk);
		s_trst();
		s_idcode();
		s_bypass();
		s_boundary();
		results();
	end

	// Watchdog far beyond the few microseconds the scans need
	initial begin
		#200000;
		err_total++;
		results();
	end
endmodule
